// *** design/ebr_pkg.sv ***
// Shared constants and types for the external bus idle-cycle and release block.
// Assumes a single bus clock and a synchronous active-high reset.
package ebr_pkg;
    localparam int          AREAS        = 8;
    localparam int          ADDR_W       = 21;
    localparam int          DATA_W       = 16;
    localparam int          ACK_W        = 4;
    localparam int          SYNC_STAGES  = 3;
    localparam int          REQ_SETUP_CY = 2;
    localparam logic [3:0]  IDLE_EN_RST  = 4'hF;
    localparam logic [1:0]  CNT_A_RST    = 2'h3;
    localparam logic [1:0]  CNT_B_RST    = 2'h3;
    localparam logic [7:0]  SEL_RST      = 8'h00;
    localparam logic [2:0]  IDLE_CNT_W0  = 3'h0;

    typedef enum logic [1:0] {
        EBR_ACC_READ,
        EBR_ACC_WRITE,
        EBR_ACC_SA_WRITE
    } ebr_acc_type;

    typedef enum {
        EBR_ST_BUS_IDLE,
        EBR_ST_GAP,
        EBR_ST_ACCESS,
        EBR_ST_REL_SETUP,
        EBR_ST_RELEASED,
        EBR_ST_REL_EXIT
    } ebr_state_type;
endpackage : ebr_pkg

// *** design/ebr_sync_if.sv ***
// Interface carrying a synchronised pin level from the sampler to the controller.
// Assumes both ends share the bus clock.
`timescale 1ns/1ns
`default_nettype none
interface ebr_sync_if;
    logic level;
    modport producer (output level);
    modport consumer (input level);
endinterface : ebr_sync_if
`default_nettype wire

// *** design/ebr_sync.sv ***
// Three-stage pin sampler; the level changes once stages two and three agree.
// Assumes an asynchronous pin input and the bus clock.
`timescale 1ns/1ns
`default_nettype none
module ebr_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    // Clock and reset.
    input  wire logic clk_in,
    input  wire logic rst_in,
    // Pin and result.
    input  wire logic pin_in,
    ebr_sync_if.producer sync_out
);
    logic [ebr_pkg::SYNC_STAGES-1:0] stage_r;
    logic                            level_r;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            stage_r <= {ebr_pkg::SYNC_STAGES{RESET_VAL}};
        end else begin
            stage_r <= {stage_r[ebr_pkg::SYNC_STAGES-2:0], pin_in};
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            level_r <= RESET_VAL;
        end else if (stage_r[1] == stage_r[2]) begin
            level_r <= stage_r[2];
        end
    end

    assign sync_out.level = level_r;
endmodule : ebr_sync
`default_nettype wire

// *** design/ebr_ctrl.sv ***
// External bus controller: idle-cycle insertion between external cycles and bus release.
// Assumes internal masters hold a request until it is started, and control bits are static ports.
`timescale 1ns/1ns
`default_nettype none
module ebr_ctrl #(
    parameter int AREAS  = ebr_pkg::AREAS,
    parameter int ADDR_W = ebr_pkg::ADDR_W,
    parameter int DATA_W = ebr_pkg::DATA_W
) (
    // Clock and reset.
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    // Configuration.
    input  wire logic              ext_mode_in,
    input  wire logic              release_enable_in,
    input  wire logic              input_buffer_control_in,
    input  wire logic              request_out_enable_in,
    input  wire logic              idle_cfg_load_in,
    input  wire logic [3:0]        idle_en_in,
    input  wire logic [1:0]        idle_count_a_in,
    input  wire logic [1:0]        idle_count_b_in,
    input  wire logic [AREAS-1:0]  idle_setting_select_per_area_in,
    // Internal access request.
    input  wire logic              acc_req_in,
    input  wire logic [1:0]        acc_kind_in,
    input  wire logic [2:0]        acc_area_in,
    input  wire logic [ADDR_W-1:0] acc_addr_in,
    input  wire logic              acc_done_in,
    input  wire logic              standby_entry_in,
    input  wire logic              clock_freq_setting_write_in,
    output logic                   acc_start_out,
    output logic                   acc_defer_out,
    // External pins.
    input  wire logic              ext_release_request_n_in,
    output logic                   bus_ack_n_out,
    output logic                   bus_return_request_n_out,
    output logic                   bus_oe_n_out,
    output logic                   data_oe_n_out,
    output logic                   idle_cycle_out,
    output logic [ADDR_W-1:0]      addr_out,
    output logic [AREAS-1:0]       chip_select_n_out,
    output logic                   strobes_n_out,
    output logic                   address_hold_out,
    output logic [ebr_pkg::ACK_W-1:0] transfer_ack_n_out,
    // Status.
    output logic [3:0]             idle_en_out
);
    // Refuses parameter values that the select decode cannot serve.
    if (AREAS != 8 || ADDR_W < 1 || DATA_W < 1) begin : g_param_check
        $error("ebr_ctrl: unsupported parameters");
    end

    ebr_sync_if req_sync ();
    ebr_sync #(.RESET_VAL(1'b1)) u_req_sync (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .pin_in   (ext_release_request_n_in),
        .sync_out (req_sync.producer)
    );

    ebr_pkg::ebr_state_type state_r;
    logic [3:0]             idle_en_r;
    logic [1:0]             cnt_a_r;
    logic [1:0]             cnt_b_r;
    logic [AREAS-1:0]       sel_r;
    logic                   prev_valid_r;
    logic [1:0]             prev_kind_r;
    logic [2:0]             prev_area_r;
    logic [2:0]             gap_r;
    logic [2:0]             gap_nxt;
    logic [1:0]             setup_r;
    logic [ADDR_W-1:0]      addr_r;
    logic                   ret_req_r;
    logic                   req_ok;
    logic                   prev_is_read;
    logic                   use_b;
    logic [2:0]             len_a;
    logic [2:0]             len_b;

    assign req_ok = ext_mode_in && release_enable_in && input_buffer_control_in && !req_sync.level;
    assign prev_is_read = prev_valid_r && (prev_kind_r == 2'(ebr_pkg::EBR_ACC_READ));
    assign use_b = sel_r[prev_area_r];
    assign len_a = {1'b0, cnt_a_r} + 3'h1;
    assign len_b = (cnt_b_r == 2'h0) ? ebr_pkg::IDLE_CNT_W0 : {1'b0, cnt_b_r} + 3'h1;

    // Gap length for the pending access against the previous one.
    always_comb begin
        gap_nxt = ebr_pkg::IDLE_CNT_W0;
        if (prev_valid_r && prev_kind_r == 2'(ebr_pkg::EBR_ACC_SA_WRITE) && idle_en_r[3]) begin
            gap_nxt = len_a;
        end else if (prev_is_read && acc_kind_in == 2'(ebr_pkg::EBR_ACC_READ) && acc_area_in != prev_area_r
                     && idle_en_r[1]) begin
            gap_nxt = use_b ? len_b : len_a;
        end else if (prev_is_read && acc_kind_in != 2'(ebr_pkg::EBR_ACC_READ) && idle_en_r[0]) begin
            gap_nxt = use_b ? len_b : len_a;
        end else if (prev_valid_r && prev_kind_r == 2'(ebr_pkg::EBR_ACC_WRITE)
                     && acc_kind_in == 2'(ebr_pkg::EBR_ACC_READ) && idle_en_r[2]) begin
            gap_nxt = len_a;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            idle_en_r <= ebr_pkg::IDLE_EN_RST;
            cnt_a_r   <= ebr_pkg::CNT_A_RST;
            cnt_b_r   <= ebr_pkg::CNT_B_RST;
            sel_r     <= ebr_pkg::SEL_RST;
        end else if (idle_cfg_load_in) begin
            idle_en_r <= idle_en_in;
            cnt_a_r   <= idle_count_a_in;
            cnt_b_r   <= idle_count_b_in;
            sel_r     <= idle_setting_select_per_area_in;
        end
    end

    // Main sequencer.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_r      <= ebr_pkg::EBR_ST_BUS_IDLE;
            gap_r        <= ebr_pkg::IDLE_CNT_W0;
            setup_r      <= 2'h0;
            prev_valid_r <= 1'b0;
            prev_kind_r  <= 2'h0;
            prev_area_r  <= 3'h0;
            addr_r       <= '0;
        end else begin
            case (state_r)
                ebr_pkg::EBR_ST_BUS_IDLE: begin
                    if (req_ok) begin
                        state_r <= ebr_pkg::EBR_ST_REL_SETUP;
                        setup_r <= 2'h0;
                    end else if (acc_req_in) begin
                        addr_r <= acc_addr_in;
                        if (gap_nxt != ebr_pkg::IDLE_CNT_W0) begin
                            state_r <= ebr_pkg::EBR_ST_GAP;
                            gap_r   <= gap_nxt;
                        end else begin
                            state_r <= ebr_pkg::EBR_ST_ACCESS;
                        end
                    end
                end
                ebr_pkg::EBR_ST_GAP: begin
                    if (gap_r == 3'h1) begin
                        state_r <= ebr_pkg::EBR_ST_ACCESS;
                    end
                    gap_r <= gap_r - 3'h1;
                end
                ebr_pkg::EBR_ST_ACCESS: begin
                    if (acc_done_in) begin
                        state_r      <= ebr_pkg::EBR_ST_BUS_IDLE;
                        prev_valid_r <= 1'b1;
                        prev_kind_r  <= acc_kind_in;
                        prev_area_r  <= acc_area_in;
                    end
                end
                ebr_pkg::EBR_ST_REL_SETUP: begin
                    if (setup_r == 2'(ebr_pkg::REQ_SETUP_CY - 1)) begin
                        state_r <= ebr_pkg::EBR_ST_RELEASED;
                    end
                    setup_r <= setup_r + 2'h1;
                end
                ebr_pkg::EBR_ST_RELEASED: begin
                    if (req_sync.level) begin
                        state_r <= ebr_pkg::EBR_ST_REL_EXIT;
                    end
                end
                ebr_pkg::EBR_ST_REL_EXIT: begin
                    state_r      <= ebr_pkg::EBR_ST_BUS_IDLE;
                    prev_valid_r <= 1'b0;
                end
                default: begin
                    state_r <= ebr_pkg::EBR_ST_BUS_IDLE;
                end
            endcase
        end
    end

    // Return request toward the external master.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ret_req_r <= 1'b0;
        end else if (state_r == ebr_pkg::EBR_ST_RELEASED && request_out_enable_in && !req_sync.level
                     && (acc_req_in || standby_entry_in || clock_freq_setting_write_in)) begin
            ret_req_r <= 1'b1;
        end else if (state_r != ebr_pkg::EBR_ST_RELEASED || req_sync.level) begin
            ret_req_r <= 1'b0;
        end
    end

    logic released;
    logic in_gap;
    assign released = (state_r == ebr_pkg::EBR_ST_RELEASED);
    assign in_gap   = (state_r == ebr_pkg::EBR_ST_GAP);

    assign acc_start_out = (state_r == ebr_pkg::EBR_ST_ACCESS);
    assign acc_defer_out = acc_req_in && (released || state_r == ebr_pkg::EBR_ST_REL_SETUP
                           || state_r == ebr_pkg::EBR_ST_REL_EXIT);
    assign bus_ack_n_out            = !released;
    assign bus_return_request_n_out = !ret_req_r;
    assign bus_oe_n_out             = released;
    assign data_oe_n_out            = released || in_gap || acc_kind_in == 2'(ebr_pkg::EBR_ACC_READ)
                                      || state_r != ebr_pkg::EBR_ST_ACCESS;
    assign idle_cycle_out           = in_gap;
    assign addr_out                 = addr_r;
    assign chip_select_n_out        = acc_start_out ? ~(AREAS'(1) << acc_area_in) : '1;
    assign strobes_n_out            = !acc_start_out;
    assign address_hold_out         = 1'b0;
    assign transfer_ack_n_out       = '1;
    assign idle_en_out              = idle_en_r;

    property p_ack_follows_release;
        @(posedge clk_in) disable iff (rst_in)
        (state_r == ebr_pkg::EBR_ST_REL_SETUP && setup_r == 2'h1) |=> !bus_ack_n_out && bus_oe_n_out;
    endproperty
    a_ack_follows_release: assert property (p_ack_follows_release) else $error("ack not low on release");

    property p_no_start_released;
        @(posedge clk_in) disable iff (rst_in)
        !bus_ack_n_out |-> !acc_start_out && transfer_ack_n_out == '1;
    endproperty
    a_no_start_released: assert property (p_no_start_released) else $error("access started while released");

    property p_gap_pins;
        @(posedge clk_in) disable iff (rst_in)
        idle_cycle_out |-> strobes_n_out && chip_select_n_out == '1 && data_oe_n_out && !address_hold_out;
    endproperty
    a_gap_pins: assert property (p_gap_pins) else $error("pins wrong in idle cycle");

    property p_reset_enables;
        @(posedge clk_in) $fell(rst_in) |-> idle_en_out == ebr_pkg::IDLE_EN_RST;
    endproperty
    a_reset_enables: assert property (p_reset_enables) else $error("idle enables not set after reset");

    property p_release_priority;
        @(posedge clk_in) disable iff (rst_in)
        (state_r == ebr_pkg::EBR_ST_BUS_IDLE && req_ok && acc_req_in) |=> state_r == ebr_pkg::EBR_ST_REL_SETUP;
    endproperty
    a_release_priority: assert property (p_release_priority) else $error("release lost priority");

    property p_ret_req;
        @(posedge clk_in) disable iff (rst_in)
        (released && request_out_enable_in && acc_req_in && !req_sync.level) |=> !bus_return_request_n_out;
    endproperty
    a_ret_req: assert property (p_ret_req) else $error("return request not driven");

    property p_no_release_disabled;
        @(posedge clk_in) disable iff (rst_in)
        (state_r == ebr_pkg::EBR_ST_BUS_IDLE && !release_enable_in && !acc_req_in) |=>
            state_r != ebr_pkg::EBR_ST_REL_SETUP;
    endproperty
    a_no_release_disabled: assert property (p_no_release_disabled) else $error("release while disabled");

    property p_exit_release;
        @(posedge clk_in) disable iff (rst_in)
        (released && req_sync.level) |=> ##1 bus_ack_n_out && !bus_oe_n_out;
    endproperty
    a_exit_release: assert property (p_exit_release) else $error("bus not returned");

    property p_ret_req_power;
        @(posedge clk_in) disable iff (rst_in)
        (released && request_out_enable_in && !req_sync.level && (standby_entry_in || clock_freq_setting_write_in))
            |=> !bus_return_request_n_out;
    endproperty
    a_ret_req_power: assert property (p_ret_req_power) else $error("return request missing");

    property p_ret_clears_with_ack;
        @(posedge clk_in) disable iff (rst_in)
        $rose(bus_ack_n_out) |-> bus_return_request_n_out;
    endproperty
    a_ret_clears_with_ack: assert property (p_ret_clears_with_ack) else $error("return request held");

    property p_release_floats;
        @(posedge clk_in) disable iff (rst_in)
        released |-> bus_oe_n_out && data_oe_n_out && chip_select_n_out == '1 && strobes_n_out;
    endproperty
    a_release_floats: assert property (p_release_floats) else $error("bus driven while released");

    property p_defer_in_release;
        @(posedge clk_in) disable iff (rst_in)
        (released && acc_req_in) |-> acc_defer_out;
    endproperty
    a_defer_in_release: assert property (p_defer_in_release) else $error("access not deferred");

    property p_gap_ends_in_access;
        @(posedge clk_in) disable iff (rst_in)
        (in_gap && gap_r == 3'h1) |=> acc_start_out && !idle_cycle_out;
    endproperty
    a_gap_ends_in_access: assert property (p_gap_ends_in_access) else $error("gap did not end");
endmodule : ebr_ctrl
`default_nettype wire

// *** testbench/ebr_master_model.sv ***
// Behavioural external bus master that asks for the bus and hands it back on request.
// Assumes the bench raises want_bus_in off the clock edge and the device answers on its pins.
`timescale 1ns/1ns
`default_nettype none
module ebr_master_model (
    // Clock, reset and bench control.
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       want_bus_in,
    input  wire logic [3:0] yield_delay_in,
    // Device pins.
    input  wire logic       bus_ack_n_in,
    input  wire logic       bus_return_request_n_in,
    output logic            ext_release_request_n_out
);
    logic [3:0] wait_r;
    logic       yielded_r;

    // Counts the return request while owning the bus, then gives the bus back.
    always_ff @(posedge clk_in) begin
        if (rst_in || !want_bus_in) begin
            wait_r    <= 4'h0;
            yielded_r <= 1'b0;
        end else if (!bus_return_request_n_in && !bus_ack_n_in && !yielded_r) begin
            if (wait_r == yield_delay_in) begin
                yielded_r <= 1'b1;
            end else begin
                wait_r <= wait_r + 4'h1;
            end
        end
    end

    // The request stays low for as long as the bus is wanted and not handed back.
    assign ext_release_request_n_out = !(want_bus_in && !yielded_r);
endmodule // ebr_master_model
`default_nettype wire

// *** testbench/ext_bus_idle_and_release_bench.sv ***
// Self-checking bench for the idle-cycle and bus-release controller.
// Assumes the controller and sampler files are compiled first; inputs change at the falling edge.
`timescale 1ns/1ns
`default_nettype none
module ext_bus_idle_and_release_bench;
    logic        clk = 1'b0, rst = 1'b1;
    logic        ext_mode = 1'b0, rel_en = 1'b0, ibc = 1'b0, rq_oe = 1'b0;
    logic        cfg_load = 1'b0, acc_req = 1'b0, acc_done = 1'b0, standby = 1'b0, clk_wr = 1'b0;
    logic [3:0]  idle_en = 4'h0;
    logic [1:0]  cnt_a = 2'h0, cnt_b = 2'h0, kind = 2'h0;
    logic [7:0]  sel = 8'h00;
    logic [2:0]  area = 3'h0;
    logic [20:0] addr = 21'h0;
    logic        want_bus = 1'b0, req_n, ack_n, ret_n, bus_oe_n, data_oe_n, gap, ahold, strobes;
    logic        acc_start, acc_defer;
    logic [20:0] addr_seen;
    logic [7:0]  cs_n;
    logic [3:0]  tack, en_seen;
    int          err_count = 0, comparisons = 0, cycles = 0, n;

    always #2 clk = ~clk;

    ebr_ctrl i_dut (.clk_in(clk), .rst_in(rst), .ext_mode_in(ext_mode), .release_enable_in(rel_en),
        .input_buffer_control_in(ibc), .request_out_enable_in(rq_oe), .idle_cfg_load_in(cfg_load),
        .idle_en_in(idle_en), .idle_count_a_in(cnt_a), .idle_count_b_in(cnt_b),
        .idle_setting_select_per_area_in(sel), .acc_req_in(acc_req), .acc_kind_in(kind),
        .acc_area_in(area), .acc_addr_in(addr), .acc_done_in(acc_done), .standby_entry_in(standby),
        .clock_freq_setting_write_in(clk_wr), .acc_start_out(acc_start), .acc_defer_out(acc_defer),
        .ext_release_request_n_in(req_n), .bus_ack_n_out(ack_n), .bus_return_request_n_out(ret_n),
        .bus_oe_n_out(bus_oe_n), .data_oe_n_out(data_oe_n), .idle_cycle_out(gap), .addr_out(addr_seen),
        .chip_select_n_out(cs_n), .strobes_n_out(strobes), .address_hold_out(ahold),
        .transfer_ack_n_out(tack), .idle_en_out(en_seen));

    ebr_master_model i_master (.clk_in(clk), .rst_in(rst), .want_bus_in(want_bus),
        .yield_delay_in(4'h4), .bus_ack_n_in(ack_n), .bus_return_request_n_in(ret_n),
        .ext_release_request_n_out(req_n));

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask

    task automatic load(input logic [3:0] en, input logic [1:0] a, input logic [1:0] b, input logic [7:0] s);
        idle_en  = en;
        cnt_a    = a;
        cnt_b    = b;
        sel      = s;
        cfg_load = 1'b1;
        cyc(1);
        cfg_load = 1'b0;
        cyc(1);
    endtask

    // One external access; exp_gap below zero skips the gap count.
    task automatic acc(input logic [1:0] k, input logic [2:0] ar, input int exp_gap);
        int gaps;
        int w;
        gaps    = 0;
        w       = 0;
        kind    = k;
        area    = ar;
        addr    = {ar, 18'h2_A5C5};
        acc_req = 1'b1;
        cyc(1);
        while (acc_start !== 1'b1 && w < 40) begin
            if (gap === 1'b1) begin
                if (gaps == 0) begin
                    chk("gap_pins", {data_oe_n, cs_n, strobes, ahold, tack, addr_seen},
                        {1'b1, 8'hFF, 1'b1, 1'b0, 4'hF, addr});
                end
                gaps++;
            end
            w++;
            cyc(1);
        end
        chk("select", {acc_start, cs_n, strobes}, {1'b1, ~(8'h01 << ar), 1'b0});
        if (exp_gap >= 0) begin
            chk("gap_count", 40'(gaps), 40'(exp_gap));
        end
        acc_done = 1'b1;
        cyc(1);
        acc_done = 1'b0;
        acc_req  = 1'b0;
        cyc(1);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            report_and_stop();
        end
    end

    initial begin
        cyc(3);
        rst = 1'b0;
        chk("reset_state", {en_seen, ack_n, ret_n}, {4'hF, 2'b11});
        acc(ebr_pkg::EBR_ACC_READ, 3'h0, -1);
        acc(ebr_pkg::EBR_ACC_READ, 3'h1, 4);
        acc(ebr_pkg::EBR_ACC_WRITE, 3'h1, 4);
        acc(ebr_pkg::EBR_ACC_READ, 3'h1, 4);
        acc(ebr_pkg::EBR_ACC_SA_WRITE, 3'h1, -1);
        acc(ebr_pkg::EBR_ACC_WRITE, 3'h1, 4);
        for (int i = 0; i < 4; i++) begin
            load(4'hF, 2'(i), 2'(i), 8'h04);
            acc(ebr_pkg::EBR_ACC_READ, 3'h3, -1);
            acc(ebr_pkg::EBR_ACC_READ, 3'h2, i + 1);
            acc(ebr_pkg::EBR_ACC_READ, 3'h4, (i == 0) ? 0 : i + 1);
            acc(ebr_pkg::EBR_ACC_WRITE, 3'h4, i + 1);
        end
        acc(ebr_pkg::EBR_ACC_READ, 3'h5, -1);
        acc(ebr_pkg::EBR_ACC_READ, 3'h5, 0);
        load(4'h0, 2'h3, 2'h3, 8'h00);
        acc(ebr_pkg::EBR_ACC_READ, 3'h6, 0);
        acc(ebr_pkg::EBR_ACC_WRITE, 3'h6, 0);
        acc(ebr_pkg::EBR_ACC_READ, 3'h7, 0);
        acc(ebr_pkg::EBR_ACC_SA_WRITE, 3'h7, 0);
        acc(ebr_pkg::EBR_ACC_READ, 3'h6, 0);
        ext_mode = 1'b1;
        rq_oe    = 1'b1;
        rel_en   = 1'b1;
        want_bus = 1'b1;
        cyc(10);
        chk("ack_without_pin_enable", ack_n, 1'b1);
        rel_en   = 1'b0;
        ibc      = 1'b1;
        cyc(10);
        chk("ack_without_enable", ack_n, 1'b1);
        want_bus = 1'b0;
        cyc(4);
        rel_en   = 1'b1;
        for (int c = 0; c < 4; c++) begin
            want_bus = 1'b1;
            if (c == 3) begin
                cyc(4);
                acc_req = 1'b1;
            end
            n = 0;
            while (ack_n !== 1'b0 && n < 30) begin
                cyc(1);
                n++;
            end
            chk("released_pins", {ack_n, bus_oe_n, data_oe_n, tack}, {3'b011, 4'hF});
            standby = (c == 0);
            clk_wr  = (c == 1);
            kind    = ebr_pkg::EBR_ACC_READ;
            area    = 3'h0;
            acc_req = (c >= 2);
            cyc(1);
            standby = 1'b0;
            clk_wr  = 1'b0;
            chk("deferred", {acc_defer, acc_start}, {(c >= 2), 1'b0});
            cyc(2);
            chk("return_request", ret_n, 1'b0);
            n = 0;
            while ((ack_n !== 1'b1 || (c >= 2 && acc_start !== 1'b1)) && n < 40) begin
                cyc(1);
                n++;
            end
            chk("resumed", {ack_n, ret_n, bus_oe_n, acc_start}, {3'b110, (c >= 2)});
            acc_done = (c >= 2);
            cyc(1);
            acc_done = 1'b0;
            acc_req  = 1'b0;
            want_bus = 1'b0;
            cyc(8);
        end
        report_and_stop();
    end
endmodule // ext_bus_idle_and_release_bench
`default_nettype wire
